// ==== hdl/accs_map.svh ====
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes inclusion by bare name from the design and testbench files.
`ifndef ACCS_MAP_SVH
`define ACCS_MAP_SVH
// Configuration word fields
`define ACCS_CHAN_MSB 3
`define ACCS_CHAN_LSB 0
`define ACCS_ACQ_MSB 5
`define ACCS_ACQ_LSB 4
`define ACCS_UBS_BIT 7
`define ACCS_SYNC_BIT 8
`define ACCS_CMD_MSB 11
`define ACCS_CMD_LSB 9
`define ACCS_BW_BIT 12
`define ACCS_CFG_RST 13'h0100
// Command codes
`define ACCS_CMD_STANDBY 3'h0
`define ACCS_CMD_START 3'h1
`define ACCS_CMD_RESET 3'h3
// Acquisition lengths in converter clocks
`define ACCS_ACQ_LEN0 7'h09
`define ACCS_ACQ_LEN1 7'h0F
`define ACCS_ACQ_LEN2 7'h2F
`define ACCS_ACQ_LEN3 7'h4F
`define ACCS_CONV_CYC 7'h0D
// Host bus timing
`define ACCS_PULSE_CYC 2'h2
// Host register offsets
`define ACCS_OFS_CFG 8'h00
`define ACCS_OFS_CMD 8'h04
`define ACCS_OFS_STAT 8'h08
`define ACCS_OFS_RES 8'h0C
`define ACCS_OFS_SDIV 8'h10
`define ACCS_CMD_GO_WR 0
`define ACCS_CMD_GO_RD 1
`define ACCS_RESP_OKAY 2'h0
`define ACCS_RESP_SLVERR 2'h2
`endif

// ==== hdl/accs_pkg.sv ====
// Types shared by both ends of the converter link.
// Assumes accs_map.svh is on the include path.
package accs_pkg;
   typedef enum logic [4:0] {
      DST_STBY = 5'h01,
      DST_IDLE = 5'h02,
      DST_WAIT = 5'h04,
      DST_ACQ = 5'h08,
      DST_CONV = 5'h10
   } accs_dev_state_t;
   typedef enum logic [3:0] {
      HST_IDLE = 4'h1,
      HST_WAIT = 4'h2,
      HST_PULSE = 4'h4,
      HST_GAP = 4'h8
   } accs_host_state_t;
endpackage

// ==== hdl/accs_link_if.sv ====
// Parallel converter link: chip select, read and write strobes, shared
// data bus, ready, standby flag and the two-way sample strobe pin.
// Assumes both ends run on the same clock; the wires resolve here.
`timescale 1ns/1ps
interface accs_link_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic [12:0] host_d_o;
   logic host_d_oe;
   logic [12:0] dev_d_o;
   logic dev_d_oe;
   logic [12:0] dbus;
   logic rdy_n;
   logic standby_flag_n;
   logic host_sync_o;
   logic host_sync_oe;
   logic dev_sync_o;
   logic dev_sync_oe;
   logic sync;
   assign dbus = host_d_oe ? host_d_o : (dev_d_oe ? dev_d_o : 13'h0000);
   assign sync = host_sync_oe ? host_sync_o : (dev_sync_oe & dev_sync_o);
   modport dev(input cs_n, rd_n, wr_n, dbus, sync,
      output dev_d_o, dev_d_oe, rdy_n, standby_flag_n, dev_sync_o, dev_sync_oe);
   modport host(input dbus, rdy_n, standby_flag_n, sync,
      output cs_n, rd_n, wr_n, host_d_o, host_d_oe, host_sync_o, host_sync_oe);
endinterface

// ==== hdl/accs_device.sv ====
// Converter end: configuration word, byte pointer, conversion sequencer.
// Assumes the host end on the same clock drives the link strobes.
// Functional notes
// - Free-running 8-bit: two byte config writes
// - Second read rise raises ready, starts acquisition
// - Strobe high after acquisition, both low done
// - 8-bit reads: lower byte then upper
// - Upper result read restarts while start held
// - Free-running 13-bit: one write, one read
// - 13-bit read gives whole result, restarts
// - Strobed 8-bit: two writes plus periodic strobes
// - Strobed 8-bit: strobe or read pair raises
// - Strobed 13-bit: strobe or read raises ready
// - Strobed: only strobe rise starts conversion
// - Channel tracked from write to strobe
// - Completion drives ready low, config may change
// - Strobed read pair raises ready, strobe converts
// - Strobed 13-bit: one write sets all
// - Standby command is code zero
// - Reset command enters ready, ready low
// - Reset aborts conversion, leaves standby
// - Host avoids bus access while converting
// - Acquisition 9, 15, 47 or 79 clocks
// - Power-up in strobed mode, strobe input
// - First byte sets upper byte select
`timescale 1ns/1ps
`include "accs_map.svh"
module accs_device
   import accs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Converter link
   accs_link_if.dev link,
   // User side
   output logic [3:0] held_channel,
   output logic tracking,
   output logic conv_done,
   output logic [12:0] result
);
   function automatic logic [6:0] acq_len(input logic [1:0] pick);
      case (pick)
         2'h0: acq_len = `ACCS_ACQ_LEN0;
         2'h1: acq_len = `ACCS_ACQ_LEN1;
         2'h2: acq_len = `ACCS_ACQ_LEN2;
         default: acq_len = `ACCS_ACQ_LEN3;
      endcase
   endfunction

   logic [12:0] cfg_r;
   logic [12:0] cfg_nxt;
   logic ptr_r;
   logic ptr_nxt;
   accs_dev_state_t st_r;
   accs_dev_state_t st_nxt;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic rd_q_r;
   logic wr_q_r;
   logic sync_q_r;
   logic [8:0] seq_r;
   logic [3:0] chan_r;
   logic [12:0] res_r;
   logic [12:0] dout_r;
   logic rdy_n_r;
   logic sync_o_r;
   logic standby_flag_n_n_r;
   logic track_r;
   logic done_r;

   wire sel = ~link.cs_n;
   wire rd_rise = sel & link.rd_n & ~rd_q_r;
   wire wr_rise = sel & link.wr_n & ~wr_q_r;
   wire wide = cfg_r[`ACCS_BW_BIT];
   wire smode = cfg_r[`ACCS_SYNC_BIT];
   wire sync_rise = smode & link.sync & ~sync_q_r;
   wire upper_wr = wr_rise & (wide | ptr_r);
   wire lower_wr = wr_rise & (wide | ~ptr_r);
   wire rd_pair = rd_rise & (wide | ptr_r);
   wire [2:0] new_cmd = cfg_nxt[`ACCS_CMD_MSB:`ACCS_CMD_LSB];
   wire cmd_start = upper_wr & (new_cmd == `ACCS_CMD_START);
   wire cmd_reset = upper_wr & (new_cmd == `ACCS_CMD_RESET);
   wire cmd_stby = upper_wr & (new_cmd == `ACCS_CMD_STANDBY);
   wire armed = cfg_r[`ACCS_CMD_MSB:`ACCS_CMD_LSB] == `ACCS_CMD_START;
   wire conv_start = (st_nxt == DST_CONV) & (st_r != DST_CONV);
   wire conv_end = (st_r == DST_CONV) & (st_nxt != DST_CONV);

   // Configuration word and byte pointer
   always_comb begin
      cfg_nxt = cfg_r;
      ptr_nxt = ptr_r;
      if (wr_rise) begin
         if (wide) begin
            cfg_nxt = link.dbus;
         end else if (ptr_r) begin
            cfg_nxt[12:8] = link.dbus[4:0];
            ptr_nxt = 1'h0;
         end else begin
            cfg_nxt[7:0] = link.dbus[7:0];
            ptr_nxt = link.dbus[`ACCS_UBS_BIT];
         end
      end else if (rd_rise & ~wide) begin
         ptr_nxt = ~ptr_r;
      end
   end

   // Conversion sequencer
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         DST_STBY: begin
            if (cmd_start) begin
               st_nxt = DST_IDLE;
            end
         end
         DST_IDLE: begin
            if (armed & smode & sync_rise) begin
               st_nxt = DST_CONV;
               cnt_nxt = `ACCS_CONV_CYC - 7'h01;
            end else if (armed & smode & rd_pair) begin
               st_nxt = DST_WAIT;
            end else if (armed & ~smode & rd_pair) begin
               st_nxt = DST_ACQ;
               cnt_nxt = acq_len(cfg_r[`ACCS_ACQ_MSB:`ACCS_ACQ_LSB]) - 7'h01;
            end
         end
         DST_WAIT: begin
            if (sync_rise) begin
               st_nxt = DST_CONV;
               cnt_nxt = `ACCS_CONV_CYC - 7'h01;
            end
         end
         DST_ACQ: begin
            if (cnt_r == 7'h00) begin
               st_nxt = DST_CONV;
               cnt_nxt = `ACCS_CONV_CYC - 7'h01;
            end else begin
               cnt_nxt = cnt_r - 7'h01;
            end
         end
         DST_CONV: begin
            if (cnt_r == 7'h00) begin
               st_nxt = DST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 7'h01;
            end
         end
         default: begin
            st_nxt = DST_IDLE;
         end
      endcase
      if (cmd_reset) begin
         st_nxt = DST_IDLE;
      end else if (cmd_stby) begin
         st_nxt = DST_STBY;
      end
   end

   // Edge history of link strobes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_q_r <= 1'h1;
         wr_q_r <= 1'h1;
         sync_q_r <= 1'h0;
      end else begin
         rd_q_r <= link.rd_n;
         wr_q_r <= link.wr_n;
         sync_q_r <= link.sync;
      end
   end

   // Power-up: standby, strobed mode, 8-bit bus
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= `ACCS_CFG_RST;
         ptr_r <= 1'h0;
         st_r <= DST_STBY;
         cnt_r <= 7'h00;
         rdy_n_r <= 1'h1;
         sync_o_r <= 1'h0;
         standby_flag_n_n_r <= 1'h0;
      end else begin
         cfg_r <= cfg_nxt;
         ptr_r <= ptr_nxt;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         rdy_n_r <= st_nxt != DST_IDLE;
         sync_o_r <= st_nxt == DST_CONV;
         standby_flag_n_n_r <= st_nxt != DST_STBY;
      end
   end

   // Channel hold, result store and read data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_r <= 4'h0;
         track_r <= 1'h0;
         seq_r <= 9'h000;
         res_r <= 13'h0000;
         dout_r <= 13'h0000;
         done_r <= 1'h0;
      end else begin
         if (conv_start) begin
            chan_r <= cfg_r[`ACCS_CHAN_MSB:`ACCS_CHAN_LSB];
         end
         if (conv_start) begin
            track_r <= 1'h0;
         end else if ((lower_wr | upper_wr) & cfg_nxt[`ACCS_SYNC_BIT]) begin
            // Mode taken from the word being written, so a pair that enters
            // strobed mode starts tracking too
            track_r <= 1'h1;
         end
         done_r <= conv_end;
         if (conv_end) begin
            seq_r <= seq_r + 9'h001;
            res_r <= {seq_r, chan_r};
         end
         if (wide) begin
            dout_r <= res_r;
         end else if (ptr_r) begin
            dout_r <= {8'h00, res_r[12:8]};
         end else begin
            dout_r <= {5'h00, res_r[7:0]};
         end
      end
   end

   assign link.dev_d_o = dout_r;
   assign link.dev_d_oe = sel & ~link.rd_n;
   assign link.rdy_n = rdy_n_r;
   assign link.standby_flag_n = standby_flag_n_n_r;
   assign link.dev_sync_o = sync_o_r;
   assign link.dev_sync_oe = ~smode;
   assign held_channel = chan_r;
   assign tracking = track_r;
   assign conv_done = done_r;
   assign result = res_r;
endmodule

// ==== hdl/accs_host.sv ====
// Host end: AXI4-Lite register slave that sequences link writes and reads
// and generates the periodic sample strobe. Assumes one clock with the device.
`timescale 1ns/1ps
`include "accs_map.svh"
module accs_host
   import accs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Converter link
   accs_link_if.host link
);
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `ACCS_OFS_CFG) | (a == `ACCS_OFS_CMD) | (a == `ACCS_OFS_STAT) |
         (a == `ACCS_OFS_RES) | (a == `ACCS_OFS_SDIV);
   endfunction

   logic aw_got_r;
   logic w_got_r;
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [12:0] cfg_r;
   logic [15:0] sdiv_r;
   logic [15:0] scnt_r;
   logic sync_o_r;
   logic [12:0] res_r;
   logic done_r;
   logic width_r;
   logic smode_r;
   accs_host_state_t st_r;
   logic op_wr_r;
   logic step_r;
   logic [1:0] pcnt_r;
   logic [12:0] hdo_r;

   wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire do_wr = aw_got_r & w_got_r & ~bvalid_r;
   wire cmd_wr = do_wr & (waddr_r == `ACCS_OFS_CMD);
   wire idle = st_r == HST_IDLE;
   wire go_wr = cmd_wr & idle & wdata_r[`ACCS_CMD_GO_WR];
   wire go_rd = cmd_wr & idle & ~wdata_r[`ACCS_CMD_GO_WR] & wdata_r[`ACCS_CMD_GO_RD];
   wire last = width_r | step_r;
   wire fin = (st_r == HST_GAP) & last;
   wire may_go = ~link.rdy_n | ~link.standby_flag_n;
   wire [31:0] stat = {28'h0000000, link.standby_flag_n, link.rdy_n, done_r, ~idle};
   wire [31:0] rmux = (s_axi_araddr == `ACCS_OFS_CFG) ? {19'h00000, cfg_r} :
      (s_axi_araddr == `ACCS_OFS_STAT) ? stat :
      (s_axi_araddr == `ACCS_OFS_RES) ? {19'h00000, res_r} :
      (s_axi_araddr == `ACCS_OFS_SDIV) ? {16'h0000, sdiv_r} : 32'h00000000;
   wire [12:0] wword = width_r ? cfg_r : (step_r ? {8'h00, cfg_r[12:8]} :
      {5'h00, 1'h1, cfg_r[6:0]});

   assign s_axi_awready = ~aw_got_r & ~bvalid_r;
   assign s_axi_wready = ~w_got_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Register slave
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'h0;
         w_got_r <= 1'h0;
         waddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'h0;
         bresp_r <= `ACCS_RESP_OKAY;
         rvalid_r <= 1'h0;
         rdata_r <= 32'h00000000;
         rresp_r <= `ACCS_RESP_OKAY;
         cfg_r <= `ACCS_CFG_RST;
         sdiv_r <= 16'h0000;
         done_r <= 1'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_r <= 1'h1;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_r <= 1'h1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_r <= 1'h0;
            w_got_r <= 1'h0;
            bvalid_r <= 1'h1;
            bresp_r <= mapped(waddr_r) ? `ACCS_RESP_OKAY : `ACCS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'h0;
         end
         if (do_wr & (waddr_r == `ACCS_OFS_CFG) & idle) begin
            cfg_r <= (cfg_r & ~wmask[12:0]) | (wdata_r[12:0] & wmask[12:0]);
         end
         if (do_wr & (waddr_r == `ACCS_OFS_SDIV)) begin
            sdiv_r <= (sdiv_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
         end
         // Completion wins over a clear in the same cycle
         done_r <= fin | (done_r & ~cmd_wr);
         if (s_axi_arvalid & s_axi_arready) begin
            rvalid_r <= 1'h1;
            rdata_r <= rmux;
            rresp_r <= mapped(s_axi_araddr) ? `ACCS_RESP_OKAY : `ACCS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'h0;
         end
      end
   end

   // Link access sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= HST_IDLE;
         op_wr_r <= 1'h0;
         step_r <= 1'h0;
         pcnt_r <= 2'h0;
         width_r <= 1'h0;
         smode_r <= 1'h1;
         res_r <= 13'h0000;
         hdo_r <= 13'h0000;
      end else begin
         hdo_r <= wword;
         case (st_r)
            HST_IDLE: begin
               if (go_wr | go_rd) begin
                  op_wr_r <= go_wr;
                  step_r <= 1'h0;
                  st_r <= HST_WAIT;
               end
            end
            HST_WAIT: begin
               if (may_go) begin
                  pcnt_r <= `ACCS_PULSE_CYC - 2'h1;
                  st_r <= HST_PULSE;
               end
            end
            HST_PULSE: begin
               if (pcnt_r == 2'h0) begin
                  st_r <= HST_GAP;
                  if (~op_wr_r & width_r) begin
                     res_r <= link.dbus;
                  end else if (~op_wr_r & step_r) begin
                     res_r[12:8] <= link.dbus[4:0];
                  end else if (~op_wr_r) begin
                     res_r[7:0] <= link.dbus[7:0];
                  end
               end else begin
                  pcnt_r <= pcnt_r - 2'h1;
               end
            end
            HST_GAP: begin
               if (last) begin
                  st_r <= HST_IDLE;
                  if (op_wr_r) begin
                     width_r <= cfg_r[`ACCS_BW_BIT];
                     smode_r <= cfg_r[`ACCS_SYNC_BIT];
                  end
               end else begin
                  step_r <= 1'h1;
                  st_r <= HST_WAIT;
               end
            end
            default: begin
               st_r <= HST_IDLE;
            end
         endcase
      end
   end

   // Periodic sample strobe while in strobed mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scnt_r <= 16'h0000;
         sync_o_r <= 1'h0;
      end else if (smode_r & (sdiv_r != 16'h0000)) begin
         scnt_r <= (scnt_r >= sdiv_r) ? 16'h0000 : scnt_r + 16'h0001;
         sync_o_r <= scnt_r >= sdiv_r;
      end else begin
         scnt_r <= 16'h0000;
         sync_o_r <= 1'h0;
      end
   end

   wire active = (st_r == HST_PULSE) | (st_r == HST_GAP);
   wire strobe = st_r == HST_PULSE;
   assign link.cs_n = ~active;
   assign link.rd_n = ~(strobe & ~op_wr_r);
   assign link.wr_n = ~(strobe & op_wr_r);
   assign link.host_d_o = hdo_r;
   assign link.host_d_oe = active & op_wr_r;
   assign link.host_sync_o = sync_o_r;
   assign link.host_sync_oe = smode_r;
endmodule

// ==== dv/accs_props.sv ====
// Concurrent checks on the converter link between the host and device ends.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/1ps
module accs_props (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link strobes
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   // Bus and pin drivers
   input wire logic host_d_oe,
   input wire logic dev_d_oe,
   input wire logic host_sync_oe,
   input wire logic dev_sync_oe,
   // Device status
   input wire logic rdy_n,
   input wire logic standby_flag_n,
   input wire logic sync
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_pwrup_strobed: assert property (
      $rose(aresetn) |-> rdy_n && !standby_flag_n && !dev_sync_oe)
      else $error("device not in strobed standby after reset");
   a_pin_single: assert property (!(host_sync_oe && dev_sync_oe))
      else $error("both ends drive the strobe pin");
   a_standby_busy: assert property (!standby_flag_n |-> rdy_n)
      else $error("ready asserted during standby");
   a_acq_min: assert property (
      $rose(sync) && dev_sync_oe |-> rdy_n && $past(rdy_n, 9))
      else $error("conversion began before minimum acquisition");
   a_conv_len: assert property (
      $rose(sync) && dev_sync_oe |-> ##12 (sync && rdy_n) ##1 (!sync && !rdy_n))
      else $error("busy output length wrong");
   a_done_both: assert property ($fell(sync) && dev_sync_oe |-> $fell(rdy_n))
      else $error("ready and busy did not fall together");
   a_read_drive: assert property (!cs_n && !rd_n |-> dev_d_oe && !host_d_oe)
      else $error("device not driving bus on read");
   a_rd_shape: assert property (
      $fell(rd_n) |-> !cs_n ##1 (!cs_n && !rd_n) ##1 (!cs_n && rd_n) ##1 cs_n)
      else $error("read pulse shape wrong");
   a_wr_shape: assert property (
      $fell(wr_n) |-> (!cs_n && host_d_oe) ##1 !wr_n ##1 (!cs_n && wr_n) ##1 cs_n)
      else $error("write pulse shape wrong");
   a_quiet_conv: assert property (
      $fell(cs_n) |-> !$past(rdy_n) || !$past(standby_flag_n))
      else $error("link access while converter busy");
endmodule

// ==== dv/accs_tb_top.sv ====
// Testbench joining host and device ends, driven over AXI4-Lite.
// Assumes the host register map and link contract of the design package.
`timescale 1ns/1ps
`include "accs_map.svh"
module accs_tb_top
   import accs_pkg::*;
   ();
   logic aclk;
   logic aresetn;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_word;
   logic [3:0] wstrb, held_channel, done_ch;
   logic [1:0] bresp, rresp, resp;
   logic tracking, conv_done;
   int done_cnt = 0;
   int mark = 0;
   logic [12:0] result, done_res;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int acq_cnt = 0;
   int acq_seen = 0;
   int acq_len[4] = '{`ACCS_ACQ_LEN0, `ACCS_ACQ_LEN1, `ACCS_ACQ_LEN2, `ACCS_ACQ_LEN3};
   accs_link_if link();
   accs_host accs_host_i(.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .link(link));
   accs_device accs_device_i(.aclk(aclk), .aresetn(aresetn), .link(link),
      .held_channel(held_channel), .tracking(tracking), .conv_done(conv_done),
      .result(result));
   accs_props accs_props_i(.aclk(aclk), .aresetn(aresetn), .cs_n(link.cs_n),
      .rd_n(link.rd_n), .wr_n(link.wr_n), .host_d_oe(link.host_d_oe),
      .dev_d_oe(link.dev_d_oe), .host_sync_oe(link.host_sync_oe),
      .dev_sync_oe(link.dev_sync_oe), .rdy_n(link.rdy_n),
      .standby_flag_n(link.standby_flag_n), .sync(link.sync));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // Cycles from ready rising to the busy output rising
   always @(negedge aclk) begin
      if (link.rdy_n !== 1'b1) begin
         acq_cnt = 0;
      end else if (link.sync !== 1'b1) begin
         acq_cnt++;
      end else if (acq_cnt != 0) begin
         acq_seen = acq_cnt;
         acq_cnt = 0;
      end
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (conv_done === 1'b1) begin
         done_cnt <= done_cnt + 1;
         done_ch <= held_channel;
         done_res <= result;
      end
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task finish_test;
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, resp);
      check("bresp", `ACCS_RESP_OKAY, resp);
   endtask
   task rd(input logic [7:0] a);
      axi_rd(a, rd_word, resp);
      check("rresp", `ACCS_RESP_OKAY, resp);
   endtask
   task wait_idle;
      rd(`ACCS_OFS_STAT);
      while (rd_word[0] !== 1'b0) rd(`ACCS_OFS_STAT);
   endtask
   task issue(input logic [12:0] c);
      wr(`ACCS_OFS_CFG, {19'h0, c});
      wr(`ACCS_OFS_CMD, 32'h1);
      wait_idle();
   endtask
   task fetch;
      wr(`ACCS_OFS_CMD, 32'h2);
      wait_idle();
      rd(`ACCS_OFS_RES);
   endtask
   task wait_conv;
      while (done_cnt == mark) @(negedge aclk);
   endtask
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ACCS_OFS_STAT);
      check("stat_reset", 2'b01, rd_word[3:2]);
      check("sync_dir", 1'b0, link.dev_sync_oe);
      axi_wr(8'h24, 32'h0, resp);
      check("bresp_unmapped", `ACCS_RESP_SLVERR, resp);
      axi_rd(8'h20, rd_word, resp);
      check("rresp_unmapped", `ACCS_RESP_SLVERR, resp);
      wr(`ACCS_OFS_CFG, 32'h1A35);
      rd(`ACCS_OFS_CFG);
      check("cfg_readback", 32'h1A35, rd_word);
      // Free-running, widths alternate 13 and 8 bits, every acquisition length
      for (int i = 0; i < 4; i++) begin
         issue({!i[0], `ACCS_CMD_START, 1'b0, 2'b00, 2'(i), 4'(i + 2)});
         mark = done_cnt;
         fetch();
         // Previous result is {sequence, channel}; upper nine bits hold the sequence
         if (i > 0) check("res_word", {9'(i - 1), 4'(i + 1)}, rd_word);
         wait_conv();
         check("acq_len", acq_len[i], acq_seen);
         check("conv_chan", i + 2, done_ch);
         check("res_out", i + 2, done_res[3:0]);
      end
      // Strobed 13-bit: read raises ready, only the strobe converts
      wr(`ACCS_OFS_SDIV, 32'h0);
      issue({1'b1, `ACCS_CMD_START, 1'b1, 2'b00, 2'b00, 4'h9});
      check("tracking", 1'b1, tracking);
      mark = done_cnt;
      fetch();
      check("rdy_wait", 1'b1, link.rdy_n);
      repeat (40) @(negedge aclk);
      check("no_conv", mark, done_cnt);
      wr(`ACCS_OFS_SDIV, 32'h3F);
      wait_conv();
      check("track_end", 1'b0, tracking);
      check("strobe_chan", 4'h9, done_ch);
      // Strobed 8-bit: read pair raises ready, conversion waits for strobe
      issue({1'b0, `ACCS_CMD_START, 1'b1, 2'b00, 2'b00, 4'h4});
      wr(`ACCS_OFS_SDIV, 32'h0);
      fetch();
      mark = done_cnt;
      repeat (40) @(negedge aclk);
      check("rdy_wait8", 1'b1, link.rdy_n);
      check("no_conv8", mark, done_cnt);
      wr(`ACCS_OFS_SDIV, 32'h3F);
      wait_conv();
      check("strobe_chan8", 4'h4, done_ch);
      wr(`ACCS_OFS_SDIV, 32'h0);
      // Standby then reset command
      issue({1'b0, `ACCS_CMD_STANDBY, 1'b0, 2'b00, 2'b00, 4'h0});
      rd(`ACCS_OFS_STAT);
      check("stat_stby", 2'b01, rd_word[3:2]);
      issue({1'b0, `ACCS_CMD_RESET, 1'b0, 2'b00, 2'b00, 4'h0});
      rd(`ACCS_OFS_STAT);
      check("stat_rst", 2'b10, rd_word[3:2]);
      finish_test();
   end
endmodule
